// ### hdl/srfu_map.svh
// Purpose: named constants for the shift, rotate and flag unit
// Assumes: 8-bit data, 8-bit flag register
// Notes: flag bit positions follow the usual status register layout
`ifndef SRFU_MAP_SVH
`define SRFU_MAP_SVH
`define SRFU_FLAG_C 3'h0
`define SRFU_FLAG_Z 3'h1
`define SRFU_FLAG_N 3'h2
`define SRFU_FLAG_V 3'h3
`define SRFU_FLAG_S 3'h4
`define SRFU_FLAG_H 3'h5
`define SRFU_FLAG_T 3'h6
`define SRFU_FLAG_I 3'h7
`define SRFU_MSB 3'h7
`define SRFU_LSB 3'h0
`define SRFU_ZERO_BYTE 8'h00
`define SRFU_FLAGS_RESET 8'h00
`define SRFU_ONE_HOT_BASE 8'h01
`endif

// ### hdl/srfu_pkg.sv
// Purpose: types for the shift, rotate and flag unit
// Assumes: nothing beyond the map header
// Notes: opcode codes are local to this block
package srfu_pkg;
  typedef enum logic [3:0] {
    SRFU_NOP = 4'h0,
    SRFU_LOGICAL_SHIFT_RIGHT_OP = 4'h1,
    SRFU_ROTATE_LEFT_CARRY_OP = 4'h2,
    SRFU_ROTATE_RIGHT_CARRY_OP = 4'h3,
    SRFU_ARITH_SHIFT_RIGHT_OP = 4'h4,
    SRFU_SWAP_OP = 4'h5,
    SRFU_INDEXED_FLAG_SET_OP = 4'h6,
    SRFU_INDEXED_FLAG_CLEAR_OP = 4'h7,
    SRFU_BIT_TO_TRANSFER_OP = 4'h8,
    SRFU_TRANSFER_TO_BIT_OP = 4'h9,
    SRFU_CARRY_SET_OP = 4'ha,
    SRFU_CARRY_CLEAR_OP = 4'hb,
    SRFU_NEGATIVE_SET_OP = 4'hc,
    SRFU_NEGATIVE_CLEAR_OP = 4'hd,
    SRFU_ZERO_SET_OP = 4'he
  } srfu_op_e;

  typedef struct packed {
    logic valid;
    srfu_op_e op;
    logic [2:0] sel;
    logic [7:0] dest;
    logic [7:0] source_operand;
  } srfu_req_s;

  typedef struct packed {
    logic valid;
    logic dest_we;
    logic [7:0] dest;
  } srfu_res_s;
endpackage

// ### hdl/srfu_shifter.sv
// Purpose: combinational shift, rotate and swap of one byte
// Assumes: operation code from the package
// Notes: carry out and flags are computed here
`timescale 1ns/1ps
`default_nettype none
`include "srfu_map.svh"
module srfu_shifter
  import srfu_pkg::*;
(
  // operation
  input wire srfu_op_e op,
  input wire logic [7:0] din,
  input wire logic carry_in,
  // result
  output logic [7:0] dout,
  output logic carry_out,
  output logic zero_out,
  output logic neg_out,
  output logic ovf_out
);
  wire logic [7:0] logic_shr_val;
  wire logic [7:0] rotl_val;
  wire logic [7:0] rotr_val;
  wire logic [7:0] arith_shr_val;
  wire logic [7:0] swap_val;
  wire logic left_move;
  assign logic_shr_val = {1'b0, din[7:1]}; // RULE1
  assign rotl_val = {din[6:0], carry_in}; // RULE2
  assign rotr_val = {carry_in, din[7:1]}; // RULE3
  assign arith_shr_val = {din[`SRFU_MSB], din[7:1]}; // RULE4
  assign swap_val = {din[3:0], din[7:4]}; // RULE5
  assign left_move = (op == SRFU_ROTATE_LEFT_CARRY_OP);
  assign dout = (op == SRFU_LOGICAL_SHIFT_RIGHT_OP) ? logic_shr_val :
                left_move ? rotl_val :
                (op == SRFU_ROTATE_RIGHT_CARRY_OP) ? rotr_val :
                (op == SRFU_ARITH_SHIFT_RIGHT_OP) ? arith_shr_val :
                (op == SRFU_SWAP_OP) ? swap_val : din;
  // left rotate takes bit 7, right moves take bit 0
  assign carry_out = left_move ? din[`SRFU_MSB] :
                     din[`SRFU_LSB]; // RULE2 RULE3 RULE12
  assign zero_out = (dout == `SRFU_ZERO_BYTE);
  assign neg_out = dout[`SRFU_MSB];
  // overflow is negative xor carry after the move
  assign ovf_out = dout[`SRFU_MSB] ^ carry_out;
endmodule
`default_nettype wire

// ### hdl/srfu_top.sv
// Purpose: single-cycle shift, rotate, swap and flag datapath
// Assumes: decoder presents one request per cycle, all take one cycle
// Notes: result and flag register update on the edge after the request
`timescale 1ns/1ps
`default_nettype none
`include "srfu_map.svh"
// What this block does
// RULE1 - logical shift right: zero into bit 7, update Z C N V, one cycle
// RULE2 - rotate left: carry into bit 0, bit 7 into carry, update Z C N V
// RULE3 - rotate right: carry into bit 7, bit 0 into carry, update Z C N V
// RULE4 - arithmetic shift right keeps bit 7, updates Z C N V
// RULE5 - nibble swap in one cycle, no flags change
// RULE6 - indexed flag set or clear writes one flag chosen by index
// RULE7 - bit store copies chosen source bit into transfer flag only
// RULE8 - bit load copies transfer flag into chosen destination bit
// RULE9 - set and clear carry touch only carry, one cycle
// RULE10 - set and clear negative touch only negative, one cycle
// RULE11 - set zero forces zero flag to one only, one cycle
// RULE12 - right shifts put old bit 0 into carry
module srfu_top
  import srfu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request from decoder and register file
  input wire srfu_req_s req,
  // result to register file
  output srfu_res_s res,
  // status register
  output logic [7:0] flag_register
);

  // registered outputs
  srfu_res_s res_reg;
  srfu_res_s res_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  // shifter results
  wire logic [7:0] sh_dout;
  wire logic sh_c;
  wire logic sh_z;
  wire logic sh_n;
  wire logic sh_v;

  // opcode decode
  wire logic take;
  wire logic op_lshr;
  wire logic op_rotl;
  wire logic op_rotr;
  wire logic op_ashr;
  wire logic op_swap;
  wire logic op_fset;
  wire logic op_fclr;
  wire logic op_tstore;
  wire logic op_tload;
  wire logic op_cset;
  wire logic op_cclr;
  wire logic op_nset;
  wire logic op_nclr;
  wire logic op_zset;
  wire logic is_shift;
  wire logic writes_dest;

  // per-operation candidate values
  wire logic [7:0] bit_mask;
  wire logic [7:0] bitload_val;
  wire logic [7:0] shift_flags;
  wire logic [7:0] fset_flags;
  wire logic [7:0] fclr_flags;
  wire logic [7:0] tstore_flags;
  wire logic [7:0] cset_flags;
  wire logic [7:0] cclr_flags;
  wire logic [7:0] nset_flags;
  wire logic [7:0] nclr_flags;
  wire logic [7:0] zset_flags;
  wire logic src_bit;

  function automatic logic is_op(input srfu_op_e got,
                                 input srfu_op_e want);
    is_op = (got == want);
  endfunction

  function automatic logic [7:0] one_hot(input logic [2:0] idx);
    one_hot = `SRFU_ONE_HOT_BASE << idx;
  endfunction

  function automatic logic [7:0] put_bit(input logic [7:0] v,
                                         input logic [2:0] idx,
                                         input logic b);
    put_bit = b ? (v | one_hot(idx)) : (v & ~one_hot(idx));
  endfunction

  srfu_shifter u_shift (
    .op(req.op),
    .din(req.dest),
    .carry_in(flags_reg[`SRFU_FLAG_C]),
    .dout(sh_dout),
    .carry_out(sh_c),
    .zero_out(sh_z),
    .neg_out(sh_n),
    .ovf_out(sh_v)
  );


  // one decode line per operation, all gated by valid
  assign take = req.valid;
  assign op_lshr = take && is_op(req.op, SRFU_LOGICAL_SHIFT_RIGHT_OP);
  assign op_rotl = take && is_op(req.op, SRFU_ROTATE_LEFT_CARRY_OP);
  assign op_rotr = take && is_op(req.op, SRFU_ROTATE_RIGHT_CARRY_OP);
  assign op_ashr = take && is_op(req.op, SRFU_ARITH_SHIFT_RIGHT_OP);
  assign op_swap = take && is_op(req.op, SRFU_SWAP_OP);
  assign op_fset = take && is_op(req.op, SRFU_INDEXED_FLAG_SET_OP);
  assign op_fclr = take && is_op(req.op, SRFU_INDEXED_FLAG_CLEAR_OP);
  assign op_tstore = take && is_op(req.op, SRFU_BIT_TO_TRANSFER_OP);
  assign op_tload = take && is_op(req.op, SRFU_TRANSFER_TO_BIT_OP);
  assign op_cset = take && is_op(req.op, SRFU_CARRY_SET_OP);
  assign op_cclr = take && is_op(req.op, SRFU_CARRY_CLEAR_OP);
  assign op_nset = take && is_op(req.op, SRFU_NEGATIVE_SET_OP);
  assign op_nclr = take && is_op(req.op, SRFU_NEGATIVE_CLEAR_OP);
  assign op_zset = take && is_op(req.op, SRFU_ZERO_SET_OP);

  // unknown codes and no-op fall through with nothing written
  assign is_shift = op_lshr || op_rotl || op_rotr || op_ashr;
  assign writes_dest = is_shift || op_swap || op_tload; // RULE5 RULE8

  // candidate flag and result values
  assign bit_mask = one_hot(req.sel);
  assign src_bit = req.source_operand[req.sel];
  assign bitload_val = put_bit(req.dest, req.sel,
                               flags_reg[`SRFU_FLAG_T]); // RULE8
  assign shift_flags = put_bit(put_bit(put_bit(put_bit(flags_reg,
                         `SRFU_FLAG_C, sh_c), `SRFU_FLAG_Z, sh_z),
                         `SRFU_FLAG_N, sh_n),
                         `SRFU_FLAG_V, sh_v); // RULE1 RULE2 RULE3 RULE4
  assign fset_flags = flags_reg | bit_mask; // RULE6
  assign fclr_flags = flags_reg & ~bit_mask; // RULE6
  assign tstore_flags = put_bit(flags_reg, `SRFU_FLAG_T,
                                src_bit); // RULE7
  assign cset_flags = put_bit(flags_reg, `SRFU_FLAG_C, 1'b1); // RULE9
  assign cclr_flags = put_bit(flags_reg, `SRFU_FLAG_C, 1'b0); // RULE9
  assign nset_flags = put_bit(flags_reg, `SRFU_FLAG_N, 1'b1); // RULE10
  assign nclr_flags = put_bit(flags_reg, `SRFU_FLAG_N, 1'b0); // RULE10
  assign zset_flags = put_bit(flags_reg, `SRFU_FLAG_Z, 1'b1); // RULE11

  // flag selection: swap, bit load and no-op keep every flag
  always_comb begin
    flags_next = flags_reg;
    if (is_shift) begin
      flags_next = shift_flags;
    end else if (op_fset) begin
      flags_next = fset_flags;
    end else if (op_fclr) begin
      flags_next = fclr_flags;
    end else if (op_tstore) begin
      flags_next = tstore_flags;
    end else if (op_cset) begin
      flags_next = cset_flags;
    end else if (op_cclr) begin
      flags_next = cclr_flags;
    end else if (op_nset) begin
      flags_next = nset_flags;
    end else if (op_nclr) begin
      flags_next = nclr_flags;
    end else if (op_zset) begin
      flags_next = zset_flags;
    end
  end

  // result selection
  always_comb begin
    res_next.valid = take;
    res_next.dest_we = writes_dest;
    res_next.dest = op_tload ? bitload_val : sh_dout; // RULE8
  end


  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_reg <= `SRFU_FLAGS_RESET;
      res_reg <= '0;
    end else begin
      flags_reg <= flags_next;
      res_reg <= res_next;
    end
  end

  assign res = res_reg;
  assign flag_register = flags_reg;
endmodule
`default_nettype wire

// ### bench/srfu_core_model.sv
// Purpose: decoder and register file model
// Assumes: one request per cycle
// Notes: a result is forwarded to the next request
`timescale 1ns/1ps
`default_nettype none
module srfu_core_model
  import srfu_pkg::*;
(
  // stimulus and unit side
  input wire logic ref_clk,
  input wire logic load,
  input wire logic [7:0] val,
  input wire srfu_req_s cmd,
  input wire srfu_res_s res,
  output srfu_req_s req
);
  logic [7:0] rd_reg;
  wire logic [7:0] rd_next = load ? val : res.dest_we ? res.dest : rd_reg;
  always_comb begin
    req = cmd;
    req.dest = rd_next;
  end
  always_ff @(posedge ref_clk) rd_reg <= rd_next;
endmodule
`default_nettype wire

// ### bench/srfu_properties.sv
// Purpose: port checks for srfu_top
// Assumes: one request per cycle
// Notes: bound to the top below
`timescale 1ns/1ps
`default_nettype none
module srfu_checker
  import srfu_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire srfu_req_s req,
  input wire srfu_res_s res,
  input wire logic [7:0] flag_register
);
  wire srfu_op_e op = req.valid ? req.op : SRFU_NOP;
  wire logic [7:0] d = req.dest;
  wire logic [7:0] q = res.dest;
  wire logic [7:0] f = flag_register;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logical_shift_a: assert property (op == SRFU_LOGICAL_SHIFT_RIGHT_OP |=>
    q == $past(d) >> 1 && f[0] == $past(d[0]))
    else $error("logical shift");
  rotate_left_a: assert property (op == SRFU_ROTATE_LEFT_CARRY_OP |=>
    q == {$past(d[6:0]), $past(f[0])} && f[0] == $past(d[7]))
    else $error("rotate left");
  rotate_right_a: assert property (op == SRFU_ROTATE_RIGHT_CARRY_OP |=>
    q == {$past(f[0]), $past(d[7:1])} && f[0] == $past(d[0]))
    else $error("rotate right");
  arith_shift_a: assert property (op == SRFU_ARITH_SHIFT_RIGHT_OP |=>
    q == {$past(d[7]), $past(d[7:1])} && f[0] == $past(d[0]))
    else $error("arith shift");
  swap_result_a: assert property (op == SRFU_SWAP_OP |=>
    q == {$past(d[3:0]), $past(d[7:4])} && $stable(f)) else $error("swap");
  flag_set_a: assert property (op == SRFU_INDEXED_FLAG_SET_OP |=>
    f == ($past(f) | 8'h01 << $past(req.sel))) else $error("flag set");
  flag_clear_a: assert property (op == SRFU_INDEXED_FLAG_CLEAR_OP |=>
    f == ($past(f) & ~(8'h01 << $past(req.sel)))) else $error("flag clear");
  carry_clear_a: assert property (op == SRFU_CARRY_CLEAR_OP |=>
    f == ($past(f) & 8'hFE)) else $error("carry clear");
  bit_store_a: assert property (op == SRFU_BIT_TO_TRANSFER_OP |=>
    f[6] == $past(req.source_operand[req.sel]) &&
    (f & 8'hBF) == ($past(f) & 8'hBF)) else $error("bit store");
  bit_load_a: assert property (op == SRFU_TRANSFER_TO_BIT_OP |=>
    q[$past(req.sel)] == $past(f[6]) && res.dest_we &&
    $stable(f)) else $error("bit load");
  negative_set_a: assert property (op == SRFU_NEGATIVE_SET_OP |=>
    f == ($past(f) | 8'h04)) else $error("negative set");
  zero_set_a: assert property (op == SRFU_ZERO_SET_OP |=>
    f == ($past(f) | 8'h02)) else $error("zero set");
endmodule
bind srfu_top srfu_checker chk (.ref_clk(ref_clk), .rst(rst), .req(req),
  .res(res), .flag_register(flag_register));
`default_nettype wire

// ### bench/tb_top.sv
// Purpose: bench for srfu_top
// Assumes: flags clear after reset
// Notes: rows run in order, so flags chain
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import srfu_pkg::*;
  typedef struct packed {srfu_op_e op; logic [2:0] sel;
    logic [7:0] val; logic [16:0] exp;} srfu_row_s;
  logic ref_clk = 1'b0, rst = 1'b1, load = 1'b1;
  logic [7:0] val = 8'h00, flag_register;
  srfu_req_s cmd = '0, req;
  srfu_res_s res;
  int failures = 0, check_count = 0;
  srfu_row_s rows [14] = '{
    '{SRFU_INDEXED_FLAG_SET_OP, 3'h0, 8'h00, 17'h0_0001},
    '{SRFU_ROTATE_LEFT_CARRY_OP, 3'h0, 8'h81, 17'h1_0309},
    '{SRFU_ROTATE_RIGHT_CARRY_OP, 3'h0, 8'h02, 17'h1_810C},
    '{SRFU_ARITH_SHIFT_RIGHT_OP, 3'h0, 8'h01, 17'h1_000B},
    '{SRFU_LOGICAL_SHIFT_RIGHT_OP, 3'h0, 8'h81, 17'h1_4009},
    '{SRFU_SWAP_OP, 3'h0, 8'hA5, 17'h1_5A09},
    '{SRFU_INDEXED_FLAG_CLEAR_OP, 3'h0, 8'h00, 17'h0_0008},
    '{SRFU_BIT_TO_TRANSFER_OP, 3'h3, 8'h08, 17'h0_0848},
    '{SRFU_TRANSFER_TO_BIT_OP, 3'h7, 8'h00, 17'h1_8048},
    '{SRFU_CARRY_SET_OP, 3'h0, 8'h00, 17'h0_0049},
    '{SRFU_CARRY_CLEAR_OP, 3'h0, 8'h00, 17'h0_0048},
    '{SRFU_NEGATIVE_SET_OP, 3'h0, 8'h00, 17'h0_004C},
    '{SRFU_NEGATIVE_CLEAR_OP, 3'h0, 8'h00, 17'h0_0048},
    '{SRFU_ZERO_SET_OP, 3'h0, 8'h00, 17'h0_004A}};
  wire logic [17:0] seen = {res, flag_register};
  initial forever #20 ref_clk = ~ref_clk;
  srfu_core_model partner (.ref_clk(ref_clk), .load(load), .val(val),
    .cmd(cmd), .res(res), .req(req));
  srfu_top DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .res(res),
    .flag_register(flag_register));
  task automatic check(input logic [17:0] got, input logic [17:0] want);
    check_count++;
    if (got !== want) begin
      failures++;
      $display("mismatch %0t %h %h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic issue(input srfu_op_e op, input logic [7:0] v,
    input logic [2:0] sel, input logic ld);
    @(posedge ref_clk);
    cmd <= '{1'b1, op, sel, 8'h00, v};
    val <= v;
    load <= ld;
  endtask
  task automatic settle();
    @(posedge ref_clk);
    cmd <= '0;
    load <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].val, rows[i].sel, 1'b1);
      settle();
      check(seen, {1'b1, rows[i].exp});
    end
    $display("rows done");
    issue(SRFU_ROTATE_LEFT_CARRY_OP, 8'h80, 3'h0, 1'b1);
    issue(SRFU_ROTATE_LEFT_CARRY_OP, 8'h00, 3'h0, 1'b0);
    settle();
    check(seen, 18'h3_0140);
    $display("chain done");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(seen, 18'h0_0000);
    $display("reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
